// >>> design/spps_defines.svh
// Constants for the stack push and pop sizing block
// Notes on behaviour
// RULE1: Default selector push lowers pointer by operand size, stores two bytes only.
// RULE2: Alternate selector push stores operand size; 32-bit upper bytes written zero.
// RULE3: Default selector pop reads two bytes, raises pointer by operand size.
// RULE4: Alternate selector pop reads operand size, raises pointer by operand size.
// RULE5: Alternate 32-bit selector access faults if bytes 3-4 exceed limit or page.
// RULE6: Default wrapping pop-to-memory stores at stack offset zero plus index.
// RULE7: Alternate wrapping pop-to-memory faults on 64K stack, else 10000h plus index.
// RULE8: Error codes push four bytes, upper half zero, pointer lowered by four.
// RULE9: Default far call resolves branch checks before any stack write.
// RULE10: Branch fault during call restores pointer to its pre-instruction value.
// RULE11: Call through 16-bit gate saves only low 16 bits of pointer.
// RULE12: Return through 16-bit gate loads popped value, upper 16 bits zero.
// RULE13: Elaboration parameter picks default or alternate variant behaviour.
`ifndef SPPS_DEFINES_SVH
`define SPPS_DEFINES_SVH
`define SPPS_BE_WORD 4'hf
`define SPPS_BE_HALF 4'h3
`define SPPS_BYTES_WORD 32'h0000_0004
`define SPPS_BYTES_HALF 32'h0000_0002
`define SPPS_WRAP_SP32 16'hfffc
`define SPPS_WRAP_SP16 16'hfffe
`define SPPS_BIG_BASE 32'h0001_0000
`define SPPS_HI_BYTE_OFS 32'h0000_0003
`define SPPS_SEG64K_LIMIT 32'h0000_ffff
`endif

// >>> design/spps_pkg.sv
// Types for the stack push and pop sizing block
package spps_pkg;
  typedef enum logic [2:0] {
    SPPS_OP_PUSH_SEL = 3'h0,
    SPPS_OP_POP_SEL = 3'h1,
    SPPS_OP_PUSH_ERR = 3'h2,
    SPPS_OP_FAR_CALL = 3'h3,
    SPPS_OP_GATE_SAVE = 3'h4,
    SPPS_OP_GATE_RET = 3'h5,
    SPPS_OP_POP_MEM = 3'h6
  } spps_op_t;
endpackage

// >>> design/spps_core.sv
// Stack access sizing: one request in, one registered memory step out
`timescale 1ns/1ps
`default_nettype none
`include "spps_defines.svh"
module spps_core #(
  parameter bit ALT_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Request from core
  input wire logic req_valid_in,
  input wire spps_pkg::spps_op_t req_op_in,
  input wire logic op32_in,
  input wire logic prot_mode_in,
  input wire logic big_stack_in,
  input wire logic [31:0] sp_in,
  input wire logic [31:0] data_in,
  input wire logic [31:0] seg_limit_in,
  input wire logic hi_page_ok_in,
  input wire logic branch_fault_in,
  input wire logic sib_sp_base_in,
  input wire logic [31:0] index_disp_in,
  // Result towards core and stack memory
  output logic res_valid_out,
  output logic mem_wr_out,
  output logic mem_rd_out,
  output logic [31:0] mem_addr_out,
  output logic [3:0] mem_be_out,
  output logic [31:0] mem_wdata_out,
  output logic [31:0] sp_out,
  output logic fault_out
);
  import spps_pkg::*;

  logic res_valid_d, mem_wr_d, mem_rd_d, fault_d;
  logic [31:0] mem_addr_d, mem_wdata_d, sp_d;
  logic [3:0] mem_be_d;
  logic [31:0] opsz;
  logic [31:0] sp_dec;
  logic [31:0] sp_inc;
  logic [31:0] hi_addr;
  logic hi_bad;
  logic wrap_pop;

  assign opsz = op32_in ? `SPPS_BYTES_WORD : `SPPS_BYTES_HALF;
  assign sp_dec = sp_in - opsz;
  assign sp_inc = sp_in + opsz;
  // Push touches the lowered pointer, pop the current one
  assign hi_addr = (req_op_in == SPPS_OP_PUSH_SEL) ? sp_dec : sp_in;
  // Bytes three and four only matter for a word access in the alternate variant
  assign hi_bad = op32_in && ((hi_addr + `SPPS_HI_BYTE_OFS) > seg_limit_in || !hi_page_ok_in);
  assign wrap_pop = !big_stack_in && sib_sp_base_in &&
    ((op32_in && sp_in[15:0] == `SPPS_WRAP_SP32) ||
     (!op32_in && sp_in[15:0] == `SPPS_WRAP_SP16));

  always_comb begin
    res_valid_d = req_valid_in;
    mem_wr_d = 1'b0;
    mem_rd_d = 1'b0;
    fault_d = 1'b0;
    mem_addr_d = sp_in;
    mem_wdata_d = 32'h0000_0000;
    mem_be_d = 4'h0;
    sp_d = sp_in;
    if (req_valid_in) begin
      case (req_op_in)
        SPPS_OP_PUSH_SEL: begin
          // RULE13: variant select
          if (!ALT_VARIANT) begin
            // RULE1: two-byte store
            mem_wr_d = 1'b1;
            mem_addr_d = sp_dec;
            mem_be_d = `SPPS_BE_HALF;
            mem_wdata_d = {16'h0000, data_in[15:0]};
            sp_d = sp_dec;
          end else if (hi_bad) begin
            // RULE5: upper bytes fault
            fault_d = 1'b1;
          end else begin
            // RULE2: operand-size store
            mem_wr_d = 1'b1;
            mem_addr_d = sp_dec;
            mem_be_d = op32_in ? `SPPS_BE_WORD : `SPPS_BE_HALF;
            mem_wdata_d = {16'h0000, data_in[15:0]};
            sp_d = sp_dec;
          end
        end
        SPPS_OP_POP_SEL: begin
          if (!ALT_VARIANT) begin
            // RULE3: two-byte read
            mem_rd_d = 1'b1;
            mem_be_d = `SPPS_BE_HALF;
            sp_d = sp_inc;
          end else if (hi_bad) begin
            // RULE5: upper bytes fault
            fault_d = 1'b1;
          end else begin
            // RULE4: operand-size read
            mem_rd_d = 1'b1;
            mem_be_d = op32_in ? `SPPS_BE_WORD : `SPPS_BE_HALF;
            sp_d = sp_inc;
          end
        end
        SPPS_OP_PUSH_ERR: begin
          // RULE8: full word error code
          mem_wr_d = 1'b1;
          mem_addr_d = sp_in - `SPPS_BYTES_WORD;
          mem_be_d = `SPPS_BE_WORD;
          mem_wdata_d = {16'h0000, data_in[15:0]};
          sp_d = sp_in - `SPPS_BYTES_WORD;
        end
        SPPS_OP_FAR_CALL: begin
          if (branch_fault_in) begin
            // RULE10: pointer kept for restart
            fault_d = 1'b1;
            sp_d = sp_in;
            // RULE9: no write on branch fault in default variant; alternate still writes
            mem_wr_d = ALT_VARIANT;
            mem_addr_d = sp_dec;
            mem_be_d = ALT_VARIANT ? (op32_in ? `SPPS_BE_WORD : `SPPS_BE_HALF) : 4'h0;
            mem_wdata_d = data_in;
          end else begin
            mem_wr_d = 1'b1;
            mem_addr_d = sp_dec;
            mem_be_d = op32_in ? `SPPS_BE_WORD : `SPPS_BE_HALF;
            mem_wdata_d = data_in;
            sp_d = sp_dec;
          end
        end
        SPPS_OP_GATE_SAVE: begin
          // RULE11: low half of pointer only
          mem_wr_d = 1'b1;
          mem_addr_d = sp_in - `SPPS_BYTES_HALF;
          mem_be_d = `SPPS_BE_HALF;
          mem_wdata_d = {16'h0000, data_in[15:0]};
          sp_d = sp_in - `SPPS_BYTES_HALF;
        end
        SPPS_OP_GATE_RET: begin
          // RULE12: upper half cleared
          sp_d = {16'h0000, data_in[15:0]};
        end
        SPPS_OP_POP_MEM: begin
          mem_wr_d = 1'b1;
          mem_be_d = op32_in ? `SPPS_BE_WORD : `SPPS_BE_HALF;
          mem_wdata_d = data_in;
          sp_d = big_stack_in ? sp_inc : {16'h0000, sp_inc[15:0]};
          mem_addr_d = (sib_sp_base_in ? sp_d : 32'h0000_0000) + index_disp_in;
          if (wrap_pop) begin
            if (!ALT_VARIANT) begin
              // RULE6: wrap to offset zero
              mem_addr_d = index_disp_in;
            end else if (!prot_mode_in || seg_limit_in <= `SPPS_SEG64K_LIMIT) begin
              // RULE7: 64K stack faults
              fault_d = 1'b1;
              mem_wr_d = 1'b0;
              mem_be_d = 4'h0;
              sp_d = sp_in;
            end else begin
              // RULE7: past the 64K mark
              mem_addr_d = `SPPS_BIG_BASE + index_disp_in;
            end
          end
        end
        default: begin
          fault_d = 1'b1;
        end
      endcase
    end
  end

  // Handshake result pulse
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_valid_out <= 1'b0;
      fault_out <= 1'b0;
    end else begin
      res_valid_out <= res_valid_d;
      fault_out <= fault_d;
    end
  end

  // Memory step and new pointer
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mem_wr_out <= 1'b0;
      mem_rd_out <= 1'b0;
      mem_addr_out <= 32'h0000_0000;
      mem_be_out <= 4'h0;
      mem_wdata_out <= 32'h0000_0000;
      sp_out <= 32'h0000_0000;
    end else begin
      mem_wr_out <= mem_wr_d;
      mem_rd_out <= mem_rd_d;
      mem_addr_out <= mem_addr_d;
      mem_be_out <= mem_be_d;
      mem_wdata_out <= mem_wdata_d;
      sp_out <= sp_d;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_sel_push_half: assert property ( // RULE1
    req_valid_in && req_op_in == SPPS_OP_PUSH_SEL && !ALT_VARIANT |=>
      mem_wr_out && mem_be_out == 4'h3 && sp_out == $past(sp_in) - $past(opsz))
    else $error("default selector push not two bytes");
  a_sel_push_size: assert property ( // RULE2
    req_valid_in && req_op_in == SPPS_OP_PUSH_SEL && ALT_VARIANT && op32_in && !hi_bad |=>
      mem_be_out == 4'hf && mem_wdata_out[31:16] == 16'h0000)
    else $error("alternate selector push wrong size");
  a_sel_pop_half: assert property ( // RULE3
    req_valid_in && req_op_in == SPPS_OP_POP_SEL && !ALT_VARIANT |=>
      mem_rd_out && mem_be_out == 4'h3 && sp_out == $past(sp_in) + $past(opsz))
    else $error("default selector pop wrong");
  a_sel_pop_size: assert property ( // RULE4
    req_valid_in && req_op_in == SPPS_OP_POP_SEL && ALT_VARIANT && !op32_in |=>
      mem_rd_out && mem_be_out == 4'h3 && sp_out == $past(sp_in) + 32'h2)
    else $error("alternate selector pop wrong");
  a_sel_hi_fault: assert property ( // RULE5
    req_valid_in && ALT_VARIANT && hi_bad &&
      (req_op_in == SPPS_OP_PUSH_SEL || req_op_in == SPPS_OP_POP_SEL) |=>
      fault_out && !mem_wr_out && !mem_rd_out)
    else $error("upper byte fault missed");
  a_wrap_zero: assert property ( // RULE6
    req_valid_in && req_op_in == SPPS_OP_POP_MEM && wrap_pop && !ALT_VARIANT |=>
      mem_wr_out && mem_addr_out == $past(index_disp_in))
    else $error("wrap pop not at offset zero");
  a_wrap_alt_fault: assert property ( // RULE7
    req_valid_in && req_op_in == SPPS_OP_POP_MEM && wrap_pop && ALT_VARIANT &&
      (!prot_mode_in || seg_limit_in <= `SPPS_SEG64K_LIMIT) |=>
      fault_out && !mem_wr_out && sp_out == $past(sp_in))
    else $error("alternate wrap pop did not fault");
  a_wrap_big_base: assert property ( // RULE7
    req_valid_in && req_op_in == SPPS_OP_POP_MEM && wrap_pop && ALT_VARIANT &&
      prot_mode_in && seg_limit_in > `SPPS_SEG64K_LIMIT |=>
      mem_wr_out && mem_addr_out == `SPPS_BIG_BASE + $past(index_disp_in))
    else $error("alternate wrap pop not past the 64K mark");
  a_err_push_word: assert property ( // RULE8
    req_valid_in && req_op_in == SPPS_OP_PUSH_ERR |=>
      mem_be_out == 4'hf && mem_wdata_out[31:16] == 16'h0000 &&
      sp_out == $past(sp_in) - 32'h4)
    else $error("error code push not a word");
  a_call_no_write: assert property ( // RULE9
    req_valid_in && req_op_in == SPPS_OP_FAR_CALL && branch_fault_in && !ALT_VARIANT |=>
      !mem_wr_out ##1 1'b1)
    else $error("far call wrote on branch fault");
  a_call_restore: assert property ( // RULE10
    req_valid_in && req_op_in == SPPS_OP_FAR_CALL && branch_fault_in |=>
      fault_out && sp_out == $past(sp_in))
    else $error("pointer not restored");
  a_gate_ret_zero: assert property ( // RULE12
    req_valid_in && req_op_in == SPPS_OP_GATE_RET |=>
      sp_out[31:16] == 16'h0000 && sp_out[15:0] == $past(data_in[15:0]))
    else $error("gate return upper half not zero");
  a_gate_save_half: assert property ( // RULE11
    req_valid_in && req_op_in == SPPS_OP_GATE_SAVE |=> mem_be_out == 4'h3)
    else $error("gate save wrote more than half");

  c_push_sel: cover property (req_valid_in && req_op_in == SPPS_OP_PUSH_SEL ##1 res_valid_out);
  c_call_fault: cover property (req_valid_in && req_op_in == SPPS_OP_FAR_CALL &&
    branch_fault_in ##1 fault_out);
  c_wrap_pop: cover property (req_valid_in && req_op_in == SPPS_OP_POP_MEM && wrap_pop);
  c_gate_ret: cover property (req_valid_in && req_op_in == SPPS_OP_GATE_RET);
endmodule // spps_core
`default_nettype wire

// >>> test/spps_stack_mem.sv
// Behavioural stack memory reached through the stack segment
`timescale 1ns/1ps
`default_nettype none
module spps_stack_mem (
  // Clock
  input wire logic sys_clk_in,
  // Store step from the block
  input wire logic wr_in,
  input wire logic [31:0] addr_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in
);
  logic [7:0] mem_q [logic [31:0]];
  // Disabled lanes keep old bytes, so partial stores show up
  always @(posedge sys_clk_in) begin
    if (wr_in) begin
      for (int i = 0; i < 4; i++) begin
        if (be_in[i]) begin
          mem_q[addr_in + 32'(i)] = wdata_in[8*i +: 8];
        end
      end
    end
  end
  function automatic logic [7:0] peek(input logic [31:0] a);
    return mem_q.exists(a) ? mem_q[a] : 8'hxx;
  endfunction
  task automatic poke(input logic [31:0] a, input logic [7:0] d);
    mem_q[a] = d;
  endtask
endmodule // spps_stack_mem
`default_nettype wire

// >>> test/stack_push_pop_sizing_bench.sv
// Self-checking bench running both variants side by side
`timescale 1ns/1ps
`default_nettype none
module stack_push_pop_sizing_bench;
  import spps_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  spps_op_t op = SPPS_OP_PUSH_SEL;
  logic o32 = 1'b0;
  logic pg = 1'b1;
  logic bf = 1'b0;
  logic pm = 1'b1;
  logic bs = 1'b0;
  logic sb = 1'b1;
  logic [31:0] sp = 32'h0, dat = 32'h0, lim = 32'h0, idx = 32'h0;
  logic d_v, d_wr, d_rd, d_flt, a_v, a_wr, a_rd, a_flt;
  logic [3:0] d_be, a_be;
  logic [31:0] d_ad, d_wd, d_sp, a_ad, a_wd, a_sp;
  int miscompares = 0;
  int checks = 0;
  always #5 clk = ~clk;
  // Mode inputs are set by the mode task so the wrap cases reach every branch
  spps_core #(.ALT_VARIANT(1'b0)) dut_u (.sys_clk_in(clk), .arst_n_in(rst_n),
    .req_valid_in(vld), .req_op_in(op), .op32_in(o32), .prot_mode_in(pm),
    .big_stack_in(bs), .sp_in(sp), .data_in(dat), .seg_limit_in(lim), .hi_page_ok_in(pg),
    .branch_fault_in(bf), .sib_sp_base_in(sb), .index_disp_in(idx), .res_valid_out(d_v),
    .mem_wr_out(d_wr), .mem_rd_out(d_rd), .mem_addr_out(d_ad), .mem_be_out(d_be),
    .mem_wdata_out(d_wd), .sp_out(d_sp), .fault_out(d_flt));
  spps_core #(.ALT_VARIANT(1'b1)) alt_u (.sys_clk_in(clk), .arst_n_in(rst_n),
    .req_valid_in(vld), .req_op_in(op), .op32_in(o32), .prot_mode_in(pm),
    .big_stack_in(bs), .sp_in(sp), .data_in(dat), .seg_limit_in(lim), .hi_page_ok_in(pg),
    .branch_fault_in(bf), .sib_sp_base_in(sb), .index_disp_in(idx), .res_valid_out(a_v),
    .mem_wr_out(a_wr), .mem_rd_out(a_rd), .mem_addr_out(a_ad), .mem_be_out(a_be),
    .mem_wdata_out(a_wd), .sp_out(a_sp), .fault_out(a_flt));
  spps_stack_mem mem_u (.sys_clk_in(clk), .wr_in(d_wr), .addr_in(d_ad), .be_in(d_be),
    .wdata_in(d_wd));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request, result sampled in its single valid cycle
  task automatic req(input spps_op_t c, input logic w, input logic [31:0] s, d,
                     input logic [31:0] l, input logic p, f, input logic [31:0] x);
    @(posedge clk);
    vld <= 1'b1;
    op <= c;
    o32 <= w;
    sp <= s;
    dat <= d;
    lim <= l;
    pg <= p;
    bf <= f;
    idx <= x;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  // Mode inputs change at an edge with no request pending
  task automatic mode(input logic p, b, s);
    @(posedge clk);
    pm <= p;
    bs <= b;
    sb <= s;
  endtask
  task automatic t_push_sel();
    mem_u.poke(32'hfe, 8'haa);
    mem_u.poke(32'hff, 8'haa);
    req(SPPS_OP_PUSH_SEL, 1'b1, 32'h100, 32'h1234, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_v, 1);
    chk(d_ad, 32'hfc);
    chk(d_be, 4'h3);
    chk(d_sp, 32'hfc);
    chk(a_be, 4'hf);
    chk(a_wd, 32'h1234);
    chk(a_sp, 32'hfc);
    @(posedge clk);
    #1;
    chk(mem_u.peek(32'hff), 8'haa);
    chk(mem_u.peek(32'hfc), 8'h34);
  endtask
  task automatic t_pop_sel();
    req(SPPS_OP_POP_SEL, 1'b1, 32'h200, 32'h0, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_rd, 1);
    chk(d_ad, 32'h200);
    chk(d_be, 4'h3);
    chk(d_sp, 32'h204);
    chk(a_be, 4'hf);
    chk(a_sp, 32'h204);
  endtask
  task automatic t_hi_fault();
    req(SPPS_OP_PUSH_SEL, 1'b1, 32'h104, 32'h0, 32'h101, 1'b1, 1'b0, 32'h0);
    chk(a_flt, 1);
    chk(d_flt, 0);
    req(SPPS_OP_PUSH_SEL, 1'b1, 32'h104, 32'h0, 32'h103, 1'b1, 1'b0, 32'h0);
    chk(a_flt, 0);
    chk(a_ad, 32'h100);
    req(SPPS_OP_POP_SEL, 1'b1, 32'h100, 32'h0, 32'hffffffff, 1'b0, 1'b0, 32'h0);
    chk(a_flt, 1);
    chk(d_flt, 0);
  endtask
  task automatic t_err_far_gate();
    req(SPPS_OP_PUSH_ERR, 1'b0, 32'h300, 32'hffffabcd, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_wd, 32'habcd);
    chk(d_be, 4'hf);
    chk(d_sp, 32'h2fc);
    chk(d_ad, 32'h2fc);
    req(SPPS_OP_FAR_CALL, 1'b1, 32'h400, 32'h5678, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_wr, 1);
    chk(d_ad, 32'h3fc);
    chk(d_wd, 32'h5678);
    chk(d_sp, 32'h3fc);
    req(SPPS_OP_FAR_CALL, 1'b1, 32'h400, 32'h0, 32'hffffffff, 1'b1, 1'b1, 32'h0);
    chk(d_flt, 1);
    chk(d_wr, 0);
    chk(d_sp, 32'h400);
    chk(a_sp, 32'h400);
    req(SPPS_OP_GATE_SAVE, 1'b1, 32'h12345678, 32'hcafe1357, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_be, 4'h3);
    chk(d_sp, 32'h12345676);
    chk(d_ad, 32'h12345676);
    chk(d_wd, 32'h1357);
    req(SPPS_OP_GATE_RET, 1'b1, 32'h12345678, 32'hdeadbeef, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_sp, 32'hbeef);
    chk(a_sp, 32'hbeef);
    chk(d_wr | d_rd, 0);
    req(spps_op_t'(3'h7), 1'b0, 32'h500, 32'h0, 32'hffffffff, 1'b1, 1'b0, 32'h0);
    chk(d_flt, 1);
    chk(d_wr | d_rd, 0);
    chk(d_sp, 32'h500);
  endtask
  task automatic t_wrap();
    req(SPPS_OP_POP_MEM, 1'b1, 32'hfffc, 32'h0, 32'hffff, 1'b1, 1'b0, 32'h10);
    chk(d_ad, 32'h10);
    chk(d_sp, 32'h0);
    chk(a_flt, 1);
    chk(a_wr, 0);
    req(SPPS_OP_POP_MEM, 1'b0, 32'hfffe, 32'h0, 32'hffff, 1'b1, 1'b0, 32'h20);
    chk(d_ad, 32'h20);
    chk(a_flt, 1);
    chk(a_sp, 32'hfffe);
    req(SPPS_OP_POP_MEM, 1'b1, 32'hfffc, 32'h0, 32'h1ffff, 1'b1, 1'b0, 32'h30);
    chk(d_ad, 32'h30);
    chk(a_flt, 0);
    chk(a_wr, 1);
    chk(a_ad, 32'h10030);
    mode(1'b0, 1'b0, 1'b1);
    req(SPPS_OP_POP_MEM, 1'b1, 32'hfffc, 32'h0, 32'h1ffff, 1'b1, 1'b0, 32'h30);
    chk(d_ad, 32'h30);
    chk(a_flt, 1);
    mode(1'b1, 1'b1, 1'b1);
    req(SPPS_OP_POP_MEM, 1'b1, 32'hfffc, 32'h0, 32'h1ffff, 1'b1, 1'b0, 32'h8);
    chk(d_sp, 32'h10000);
    chk(d_ad, 32'h10008);
    chk(a_ad, 32'h10008);
    mode(1'b1, 1'b0, 1'b0);
    req(SPPS_OP_POP_MEM, 1'b1, 32'hfffc, 32'h0, 32'hffff, 1'b1, 1'b0, 32'h40);
    chk(d_ad, 32'h40);
    chk(a_flt, 0);
    chk(a_ad, 32'h40);
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run needs about fifty cycles
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_push_sel();
    t_pop_sel();
    t_hi_fault();
    t_err_far_gate();
    t_wrap();
    end_of_test();
  end
endmodule // stack_push_pop_sizing_bench
`default_nettype wire
